// ### include/sfp_pkg.sv
// Constants, types and timing for the serial flash/EEPROM programming port
package sfp_pkg;
  // ********************************************************************
  // Instruction codes
  // ********************************************************************
  localparam logic [7:0] SFP_CMD_ENABLE  = 8'hAC;
  localparam logic [7:0] SFP_ENABLE_B2   = 8'h53;
  localparam logic [2:0] SFP_ERASE_B2    = 3'h4;
  localparam logic [7:0] SFP_CMD_LOAD_LO = 8'h40;
  localparam logic [7:0] SFP_CMD_LOAD_HI = 8'h48;
  localparam logic [7:0] SFP_CMD_PAGE_WR = 8'h4C;
  localparam logic [7:0] SFP_CMD_EE_WR   = 8'hC0;
  localparam logic [7:0] SFP_CMD_RD_LO   = 8'h20;
  localparam logic [7:0] SFP_CMD_RD_HI   = 8'h28;
  localparam logic [7:0] SFP_CMD_EE_RD   = 8'hA0;
  localparam logic [7:0] SFP_ERASED_BYTE = 8'hFF;
  localparam int         SFP_HI_BIT      = 3;

  // ********************************************************************
  // Geometry
  // ********************************************************************
  localparam int SFP_FLASH_AW = 16;
  localparam int SFP_PAGE_W   = 7;
  localparam int SFP_EE_AW    = 12;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int SFP_CLK_KHZ       = 200000;
  localparam int SFP_FLASH_WAIT_MS = 5;
  localparam int SFP_EE_WAIT_MS    = 10;
  localparam int SFP_ERASE_WAIT_MS = 10;
  localparam int SFP_FLASH_WAIT_CYC = SFP_FLASH_WAIT_MS * SFP_CLK_KHZ;
  localparam int SFP_EE_WAIT_CYC    = SFP_EE_WAIT_MS * SFP_CLK_KHZ;
  localparam int SFP_ERASE_WAIT_CYC = SFP_ERASE_WAIT_MS * SFP_CLK_KHZ;
  localparam logic [1:0] SFP_PEN_SAMPLE = 2'h3;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] a;
    logic [7:0] b;
  } sfp_instr_t;

  typedef enum logic [1:0] {
    SFP_IDLE,
    SFP_PAGE,
    SFP_EEWR,
    SFP_ERASE
  } sfp_op_t;
endpackage : sfp_pkg

// ### rtl/_unused_placeholder_never.sv
// Intentionally empty file holding no logic
`timescale 1ns/1ps

// ### rtl/sfp_prog_port.sv
// Serial programming port for on-chip flash and EEPROM
`timescale 1ns/1ps

// Contract
// - Writes refused until programming enable done
// - Input bit captured on serial rising edge
// - Output bit changes on serial falling edge
// - Entry pin sampled only at power-on
// - Second enable byte echoed during third
// - Page buffer loaded byte by byte
// - Page write commits buffer to page
// - EEPROM write auto-erases and programs byte
// - Chip erase sets both arrays to ones
// - Read returns addressed content on output, FF while a write is busy
// - Enable code is AC then 53
// - Page write code is 4C
// - EEPROM write code is C0
module sfp_prog_port
  import sfp_pkg::*;
#(
  parameter int FLASH_AW       = sfp_pkg::SFP_FLASH_AW,
  parameter int PAGE_W         = sfp_pkg::SFP_PAGE_W,
  parameter int EE_AW          = sfp_pkg::SFP_EE_AW,
  parameter int FLASH_WAIT_CYC = sfp_pkg::SFP_FLASH_WAIT_CYC,
  parameter int EE_WAIT_CYC    = sfp_pkg::SFP_EE_WAIT_CYC,
  parameter int ERASE_WAIT_CYC = sfp_pkg::SFP_ERASE_WAIT_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Device pins
  input  wire logic reset_pin_n,
  input  wire logic program_entry_pin_n,
  // Serial link
  input  wire logic prog_sck,
  input  wire logic prog_serial_in,
  output logic      prog_serial_out,
  // Status
  output logic      prog_enabled,
  output logic      prog_busy
);
  import sfp_pkg::*;

  // ********************************************************************
  // Pin synchronisers
  // ********************************************************************
  logic [1:0] sck_q;
  logic [1:0] sdi_q;
  logic [1:0] rstp_q;
  logic [1:0] pen_q;
  logic       sck_d_r;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sck_q   <= 2'h0;
      sdi_q   <= 2'h0;
      rstp_q  <= 2'h3;
      pen_q   <= 2'h3;
      sck_d_r <= 1'b0;
    end else begin
      sck_q   <= {sck_q[0], prog_sck};
      sdi_q   <= {sdi_q[0], prog_serial_in};
      rstp_q  <= {rstp_q[0], reset_pin_n};
      pen_q   <= {pen_q[0], program_entry_pin_n};
      sck_d_r <= sck_q[1];
    end
  end

  logic sck_s;
  logic sdi_s;
  logic sck_rise;
  logic sck_fall;
  assign sck_s    = sck_q[1];
  assign sdi_s    = sdi_q[1];
  assign sck_rise = sck_s & ~sck_d_r;
  assign sck_fall = ~sck_s & sck_d_r;

  // ********************************************************************
  // Storage
  // ********************************************************************
  logic [15:0] flash_mem [2**FLASH_AW];
  logic [7:0]  ee_mem    [2**EE_AW];
  logic [15:0] page_buf  [2**PAGE_W];
  logic [15:0] fl_rd_q;
  logic [7:0]  ee_rd_q;

  // ********************************************************************
  // State
  // ********************************************************************
  logic [2:0]          bit_cnt_r,  bit_cnt_nxt;
  logic [1:0]          byte_cnt_r, byte_cnt_nxt;
  logic [7:0]          rx_r,       rx_nxt;
  logic [7:0]          tx_r,       tx_nxt;
  logic                sdo_r,      sdo_nxt;
  logic                en_r,       en_nxt;
  sfp_instr_t          ins_r,      ins_nxt;
  sfp_op_t             op_r,       op_nxt;
  logic [31:0]         wait_r,     wait_nxt;
  logic [FLASH_AW-1:0] sweep_r,    sweep_nxt;
  logic [FLASH_AW-1:0] page_r,     page_nxt;
  logic [1:0]          rd_stg_r,   rd_stg_nxt;
  logic [1:0]          pen_cnt_r,  pen_cnt_nxt;
  logic                pen_lat_r,  pen_lat_nxt;

  logic                session;
  logic                byte_done;
  logic [7:0]          rx_byte;
  logic                exec;
  logic                is_read;
  logic [15:0]         word_addr;
  logic                pb_we;
  logic [PAGE_W-1:0]   pb_idx;
  logic                fl_we;
  logic [FLASH_AW-1:0] fl_addr;
  logic [15:0]         fl_wdata;
  logic                ee_we;
  logic [EE_AW-1:0]    ee_addr;
  logic [7:0]          ee_wdata;
  logic                sweep_end;

  // Entry pin is caught once after power-on and held until the next one
  assign session   = ~rstp_q[1] | pen_lat_r;
  assign byte_done = session & sck_rise & (bit_cnt_r == 3'h7);
  assign rx_byte   = {rx_r[6:0], sdi_s};
  assign exec      = byte_done & (byte_cnt_r == 2'h3);
  assign is_read   = (ins_r.op == SFP_CMD_RD_LO) | (ins_r.op == SFP_CMD_RD_HI) |
                     (ins_r.op == SFP_CMD_EE_RD);
  assign word_addr = {ins_r.a, ins_r.b};
  assign pb_idx    = ins_r.b[PAGE_W-1:0];
  assign sweep_end = (op_r == SFP_PAGE) ? (&sweep_r[PAGE_W-1:0]) : (&sweep_r);

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    bit_cnt_nxt  = bit_cnt_r;
    byte_cnt_nxt = byte_cnt_r;
    rx_nxt       = rx_r;
    tx_nxt       = tx_r;
    sdo_nxt      = sdo_r;
    en_nxt       = en_r;
    ins_nxt      = ins_r;
    op_nxt       = op_r;
    wait_nxt     = wait_r;
    sweep_nxt    = sweep_r;
    page_nxt     = page_r;
    rd_stg_nxt   = {rd_stg_r[0], 1'b0};
    pen_cnt_nxt  = pen_cnt_r;
    pen_lat_nxt  = pen_lat_r;
    pb_we        = 1'b0;
    ee_we        = 1'b0;
    ee_addr      = word_addr[EE_AW-1:0];
    ee_wdata     = rx_byte;
    fl_we        = 1'b0;
    fl_addr      = {page_r[FLASH_AW-1:PAGE_W], sweep_r[PAGE_W-1:0]};
    fl_wdata     = page_buf[sweep_r[PAGE_W-1:0]];
    if (pen_cnt_r != SFP_PEN_SAMPLE) begin
      pen_cnt_nxt = pen_cnt_r + 2'h1;
      if (pen_cnt_r == 2'h2) begin
        pen_lat_nxt = ~pen_q[1];
      end
    end
    if (!session) begin
      // Leaving the session drops sync and enable; a reset pulse resyncs
      bit_cnt_nxt  = 3'h0;
      byte_cnt_nxt = 2'h0;
      tx_nxt       = 8'h00;
      sdo_nxt      = 1'b0;
      en_nxt       = 1'b0;
      rd_stg_nxt   = 2'h0;
    end else begin
      if (sck_rise) begin
        rx_nxt      = rx_byte;
        bit_cnt_nxt = bit_cnt_r + 3'h1;
      end
      if (sck_fall) begin
        sdo_nxt = tx_r[7];
        tx_nxt  = {tx_r[6:0], 1'b0};
      end
      if (byte_done) begin
        byte_cnt_nxt = byte_cnt_r + 2'h1;
        tx_nxt       = rx_byte;
        case (byte_cnt_r)
          2'h0:    ins_nxt.op = rx_byte;
          2'h1:    ins_nxt.a  = rx_byte;
          2'h2: begin
            ins_nxt.b  = rx_byte;
            rd_stg_nxt = 2'h1;
          end
          default: ins_nxt.op = ins_r.op;
        endcase
      end
      // Read data lands two cycles after the address byte, well before the next fall
      if (rd_stg_r[1] && is_read) begin
        if (op_r != SFP_IDLE) begin
          tx_nxt = SFP_ERASED_BYTE;
        end else if (ins_r.op == SFP_CMD_EE_RD) begin
          tx_nxt = ee_rd_q;
        end else if (ins_r.op[SFP_HI_BIT]) begin
          tx_nxt = fl_rd_q[15:8];
        end else begin
          tx_nxt = fl_rd_q[7:0];
        end
      end
      if (exec) begin
        if (ins_r.op == SFP_CMD_ENABLE && ins_r.a == SFP_ENABLE_B2) begin
          en_nxt = 1'b1;
        end else if (en_r && op_r == SFP_IDLE) begin
          if (ins_r.op == SFP_CMD_ENABLE && ins_r.a[7:5] == SFP_ERASE_B2) begin
            op_nxt    = SFP_ERASE;
            wait_nxt  = ERASE_WAIT_CYC;
            sweep_nxt = '0;
          end else if (ins_r.op == SFP_CMD_LOAD_LO || ins_r.op == SFP_CMD_LOAD_HI) begin
            pb_we = 1'b1;
          end else if (ins_r.op == SFP_CMD_PAGE_WR) begin
            op_nxt    = SFP_PAGE;
            wait_nxt  = FLASH_WAIT_CYC;
            sweep_nxt = '0;
            page_nxt  = word_addr[FLASH_AW-1:0];
          end else if (ins_r.op == SFP_CMD_EE_WR) begin
            op_nxt   = SFP_EEWR;
            wait_nxt = EE_WAIT_CYC;
            ee_we    = 1'b1;
          end
        end
      end
    end
    // Self-timed writes finish even if the session ends meanwhile
    case (op_r)
      SFP_PAGE: begin
        fl_we = 1'b1;
      end
      SFP_ERASE: begin
        fl_we    = 1'b1;
        fl_addr  = sweep_r;
        fl_wdata = {SFP_ERASED_BYTE, SFP_ERASED_BYTE};
        ee_we    = 1'b1;
        ee_addr  = sweep_r[EE_AW-1:0];
        ee_wdata = SFP_ERASED_BYTE;
      end
      default: fl_we = 1'b0;
    endcase
    if (op_r != SFP_IDLE) begin
      if (!sweep_end) begin
        sweep_nxt = sweep_r + FLASH_AW'(1);
      end
      if (wait_r != 32'h0) begin
        wait_nxt = wait_r - 32'h1;
      end else if (sweep_end) begin
        op_nxt = SFP_IDLE;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_cnt_r  <= 3'h0;
      byte_cnt_r <= 2'h0;
      rx_r       <= 8'h00;
      tx_r       <= 8'h00;
      sdo_r      <= 1'b0;
      en_r       <= 1'b0;
      ins_r      <= '0;
      op_r       <= SFP_IDLE;
      wait_r     <= 32'h0;
      sweep_r    <= '0;
      page_r     <= '0;
      rd_stg_r   <= 2'h0;
      pen_cnt_r  <= 2'h0;
      pen_lat_r  <= 1'b0;
    end else begin
      bit_cnt_r  <= bit_cnt_nxt;
      byte_cnt_r <= byte_cnt_nxt;
      rx_r       <= rx_nxt;
      tx_r       <= tx_nxt;
      sdo_r      <= sdo_nxt;
      en_r       <= en_nxt;
      ins_r      <= ins_nxt;
      op_r       <= op_nxt;
      wait_r     <= wait_nxt;
      sweep_r    <= sweep_nxt;
      page_r     <= page_nxt;
      rd_stg_r   <= rd_stg_nxt;
      pen_cnt_r  <= pen_cnt_nxt;
      pen_lat_r  <= pen_lat_nxt;
    end
  end

  // ********************************************************************
  // Arrays
  // ********************************************************************
  // No reset on arrays; contents are undefined until the first chip erase
  always_ff @(posedge clk) begin
    if (pb_we) begin
      if (ins_r.op[SFP_HI_BIT]) begin
        page_buf[pb_idx][15:8] <= rx_byte;
      end else begin
        page_buf[pb_idx][7:0] <= rx_byte;
      end
    end
    if (fl_we) begin
      flash_mem[fl_addr] <= fl_wdata;
    end
    if (ee_we) begin
      ee_mem[ee_addr] <= ee_wdata;
    end
    fl_rd_q <= flash_mem[word_addr[FLASH_AW-1:0]];
    ee_rd_q <= ee_mem[word_addr[EE_AW-1:0]];
  end

  assign prog_serial_out = sdo_r;
  assign prog_enabled    = en_r;
  assign prog_busy       = (op_r != SFP_IDLE);

  // ********************************************************************
  // Checks
  // ********************************************************************
  a_enable_gate: assert property (@(posedge clk) disable iff (sys_rst)
    (op_r != SFP_IDLE && $past(op_r) == SFP_IDLE) |-> $past(en_r))
    else $error("write started without programming enable");

  a_rx_capture: assert property (@(posedge clk) disable iff (sys_rst)
    (session && sck_rise) |=> (rx_r[0] == $past(sdi_s)))
    else $error("input bit not captured on rising edge");

  a_tx_on_fall: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(sdo_r) |-> ($past(sck_fall) || !$past(session)))
    else $error("output bit changed away from falling edge");

  a_echo_second: assert property (@(posedge clk) disable iff (sys_rst)
    (byte_done && byte_cnt_r == 2'h1) |=> (tx_r == ins_r.a && byte_cnt_r == 2'h2))
    else $error("second byte not echoed");

  a_page_load: assert property (@(posedge clk) disable iff (sys_rst)
    (pb_we && !ins_r.op[SFP_HI_BIT]) |=> (page_buf[$past(pb_idx)][7:0] == $past(rx_byte)))
    else $error("page buffer low byte not loaded");

  a_page_commit: assert property (@(posedge clk) disable iff (sys_rst)
    (op_r == SFP_PAGE) |-> (fl_we && fl_addr[FLASH_AW-1:PAGE_W] == page_r[FLASH_AW-1:PAGE_W]))
    else $error("page write outside selected page");

  a_ee_write: assert property (@(posedge clk) disable iff (sys_rst)
    (exec && ee_we && op_r == SFP_IDLE) |=>
      (op_r == SFP_EEWR && ee_mem[$past(ee_addr)] == $past(rx_byte)))
    else $error("EEPROM byte not written");

  a_erase_ones: assert property (@(posedge clk) disable iff (sys_rst)
    (op_r == SFP_ERASE) |-> (fl_we && fl_wdata == 16'hFFFF && ee_we && ee_wdata == 8'hFF))
    else $error("chip erase not writing ones");

  a_poll_value: assert property (@(posedge clk) disable iff (sys_rst)
    (session && rd_stg_r[1] && is_read && op_r != SFP_IDLE) |=> (tx_r == 8'hFF))
    else $error("busy read not returning FF");

  a_enable_code: assert property (@(posedge clk) disable iff (sys_rst)
    (exec && ins_r.op == 8'hAC && ins_r.a == 8'h53) |=> en_r)
    else $error("enable instruction ignored");

  a_byte_order: assert property (@(posedge clk) disable iff (sys_rst)
    (byte_done && byte_cnt_r == 2'h0) |=> (ins_r.op == $past(rx_byte)))
    else $error("first byte not taken as opcode");
endmodule : sfp_prog_port

// ### tb/sfp_programmer.sv
// Programmer model that drives the serial programming link
`timescale 1ns/1ps
module sfp_programmer #(
  parameter int LOW_NS    = 32,
  parameter int HIGH_NS   = 32,
  parameter int ENTRY_CLK = 50
) (
  // Clock
  input  wire logic clk,
  // Link
  output logic      reset_pin_n,
  output logic      prog_sck,
  output logic      prog_serial_in,
  input  wire logic prog_serial_out
);
  // ********************************************************************
  // Power-up state
  // ********************************************************************
  initial begin
    reset_pin_n    = 1'b0;
    prog_sck       = 1'b0;
    prog_serial_in = 1'b0;
  end

  // ********************************************************************
  // Session control
  // ********************************************************************
  // Real wait is 20 ms; shortened so the run stays small
  task automatic start;
    @(negedge clk);
    reset_pin_n = 1'b0;
    repeat (ENTRY_CLK) @(negedge clk);
  endtask : start

  task automatic stop;
    @(negedge clk);
    reset_pin_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask : stop

  // Always four bytes, even when the echo looks wrong
  // Link clock free of clk at 64 ns a bit; whole-ns edges stay clear of rising clk
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    for (int i = 31; i >= 0; i--) begin
      prog_serial_in = tx[i];
      #(LOW_NS);
      rx[i]    = prog_serial_out;
      prog_sck = 1'b1;
      #(HIGH_NS);
      prog_sck = 1'b0;
    end
    // Released data line must not keep its last level
    prog_serial_in = ~tx[0];
    #(LOW_NS);
  endtask : xfer
endmodule : sfp_programmer

// ### tb/tb_sfp_prog_port.sv
// Self-checking bench for the serial programming port
`timescale 1ns/1ps
module tb_sfp_prog_port;
  import sfp_pkg::*;
  localparam int WAIT_CYC = 2000;
  logic        clk;
  logic        sys_rst;
  logic        program_entry_pin_n;
  logic        reset_pin_n;
  logic        prog_sck;
  logic        prog_serial_in;
  logic        prog_serial_out;
  logic        prog_enabled;
  logic        prog_busy;
  logic [31:0] rx;
  int          fails;
  int          checks;

  sfp_prog_port #(
    .FLASH_AW       (10),
    .PAGE_W         (7),
    .EE_AW          (8),
    .FLASH_WAIT_CYC (WAIT_CYC),
    .EE_WAIT_CYC    (WAIT_CYC),
    .ERASE_WAIT_CYC (WAIT_CYC)
  ) u_dut (
    .clk                 (clk),
    .sys_rst             (sys_rst),
    .reset_pin_n         (reset_pin_n),
    .program_entry_pin_n (program_entry_pin_n),
    .prog_sck            (prog_sck),
    .prog_serial_in      (prog_serial_in),
    .prog_serial_out     (prog_serial_out),
    .prog_enabled        (prog_enabled),
    .prog_busy           (prog_busy)
  );

  sfp_programmer u_prog (
    .clk             (clk),
    .reset_pin_n     (reset_pin_n),
    .prog_sck        (prog_sck),
    .prog_serial_in  (prog_serial_in),
    .prog_serial_out (prog_serial_out)
  );

  // ********************************************************************
  // Helpers
  // ********************************************************************
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic cmd(input logic [31:0] w);
    u_prog.xfer(w, rx);
  endtask : cmd

  // Bounded poll of the busy flag
  task automatic wait_idle;
    int n;
    n = 0;
    while (prog_busy !== 1'b0 && n < 3 * WAIT_CYC) begin
      @(negedge clk);
      n++;
    end
    check("busy", 8'h00, {7'h00, prog_busy});
  endtask : wait_idle

  task automatic results;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  // ********************************************************************
  // Scenarios
  // ********************************************************************
  task automatic t_enable;
    u_prog.start();
    check("enabled", 8'h00, {7'h00, prog_enabled});
    cmd({SFP_CMD_ENABLE, SFP_ENABLE_B2, 16'h0000});
    check("echo1", 8'hAC, rx[23:16]);
    check("echo2", 8'h53, rx[15:8]);
    check("enabled", 8'h01, {7'h00, prog_enabled});
    $display("t_enable done");
  endtask : t_enable

  task automatic t_erase;
    cmd(32'hAC80_0000);
    check("busy", 8'h01, {7'h00, prog_busy});
    wait_idle();
    cmd(32'h2000_0000);
    check("flash_lo", 8'hFF, rx[7:0]);
    cmd(32'h2803_FF00);
    check("flash_hi", 8'hFF, rx[7:0]);
    cmd(32'hA000_FF00);
    check("ee", 8'hFF, rx[7:0]);
    $display("t_erase done");
  endtask : t_erase

  task automatic t_eeprom;
    cmd(32'hC000_05A5);
    cmd(32'hA000_0500);
    check("ee_poll", 8'hFF, rx[7:0]);
    wait_idle();
    cmd(32'hA000_0500);
    check("ee_rd", 8'hA5, rx[7:0]);
    // Rewrite without erase: old bits must not survive
    cmd(32'hC000_053C);
    wait_idle();
    cmd(32'hA000_0500);
    check("ee_rewr", 8'h3C, rx[7:0]);
    $display("t_eeprom done");
  endtask : t_eeprom

  task automatic t_page;
    cmd(32'h4000_0034);
    cmd(32'h4800_0012);
    cmd(32'h4000_7FCD);
    cmd(32'h4800_7FAB);
    cmd({SFP_CMD_PAGE_WR, 24'h0080_00});
    check("busy", 8'h01, {7'h00, prog_busy});
    cmd(32'h2000_8000);
    check("pg_poll", 8'hFF, rx[7:0]);
    wait_idle();
    cmd(32'h2000_8000);
    check("w0_lo", 8'h34, rx[7:0]);
    cmd(32'h2800_8000);
    check("w0_hi", 8'h12, rx[7:0]);
    cmd(32'h2000_FF00);
    check("w127_lo", 8'hCD, rx[7:0]);
    cmd(32'h2800_FF00);
    check("w127_hi", 8'hAB, rx[7:0]);
    cmd(32'h2000_0000);
    check("page0", 8'hFF, rx[7:0]);
    $display("t_page done");
  endtask : t_page

  task automatic t_refused;
    u_prog.stop();
    check("enabled", 8'h00, {7'h00, prog_enabled});
    check("out_idle", 8'h00, {7'h00, prog_serial_out});
    u_prog.start();
    cmd(32'hC000_0755);
    check("busy", 8'h00, {7'h00, prog_busy});
    cmd({SFP_CMD_ENABLE, SFP_ENABLE_B2, 16'h0000});
    cmd(32'hA000_0700);
    check("ee_kept", 8'hFF, rx[7:0]);
    $display("t_refused done");
  endtask : t_refused

  task automatic t_entry_pin;
    u_prog.stop();
    program_entry_pin_n = 1'b0;
    sys_rst             = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    repeat (8) @(negedge clk);
    cmd({SFP_CMD_ENABLE, SFP_ENABLE_B2, 16'h0000});
    check("pin_echo", 8'h53, rx[15:8]);
    // The pin only counts at power-on, so releasing it changes nothing
    program_entry_pin_n = 1'b1;
    repeat (4) @(negedge clk);
    check("enabled", 8'h01, {7'h00, prog_enabled});
    cmd(32'hA000_0500);
    check("pin_rd", 8'h3C, rx[7:0]);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    repeat (8) @(negedge clk);
    check("enabled", 8'h00, {7'h00, prog_enabled});
    $display("t_entry_pin done");
  endtask : t_entry_pin

  // ********************************************************************
  // Clock, reset, sequence, watchdog
  // ********************************************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    fails               = 0;
    checks              = 0;
    sys_rst             = 1'b1;
    program_entry_pin_n = 1'b1;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    t_enable();
    t_erase();
    t_eeprom();
    t_page();
    t_refused();
    t_entry_pin();
    results();
  end

  // About 26 instructions of 420 cycles plus write waits
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    results();
  end
endmodule : tb_sfp_prog_port
